//--- design/ulp_params.svh
/*
  Constants for the link power-state block: clock rate, timer lengths in their
  own units and as clock cycles, counter limits and the compliance pattern span.
  Assumes a 10 MHz clock; included by bare name from the interface, timer and top design files.
*/
`ifndef ULP_PARAMS_SVH
`define ULP_PARAMS_SVH

`define ULP_CLK_KHZ      10000
`define ULP_TW           22
// times in microseconds
`define ULP_T_LCMD_US    1000
`define ULP_T_IDLE_US    10
`define ULP_T_PING_US    300000
`define ULP_T_HS_UX_US   2000
`define ULP_T_HS_U3_US   10000
`define ULP_T_TERM_US    100000
`define ULP_T_RETRY_US   100000
`define ULP_US2CYC(t)    (((t) * `ULP_CLK_KHZ) / 1000)
`define ULP_LCMD_CYC     `ULP_US2CYC(`ULP_T_LCMD_US)
`define ULP_IDLE_CYC     `ULP_US2CYC(`ULP_T_IDLE_US)
`define ULP_PING_CYC     `ULP_US2CYC(`ULP_T_PING_US)
`define ULP_HS_UX_CYC    `ULP_US2CYC(`ULP_T_HS_UX_US)
`define ULP_HS_U3_CYC    `ULP_US2CYC(`ULP_T_HS_U3_US)
`define ULP_TERM_CYC     `ULP_US2CYC(`ULP_T_TERM_US)
`define ULP_RETRY_CYC    `ULP_US2CYC(`ULP_T_RETRY_US)
// consecutive-failure limits, as last count before the exit; then compliance pattern span and timer count
`define ULP_HP_LAST      2'h3
`define ULP_U3F_LAST     2'h2
`define ULP_CPAT_FIRST   4'h0
`define ULP_CPAT_LAST    4'h8
`define ULP_NTMR         7

`endif

//--- design/ulp_pkg.sv
/*
  Types shared by the link power-state block: the link state encoding.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package ulp_pkg;
  // gray steps along out -> u0 -> u1 -> u2 -> u3
  typedef enum logic [3:0] {
    ULP_ST_RXDET = 4'h0,
    ULP_ST_U0    = 4'h1,
    ULP_ST_U1    = 4'h3,
    ULP_ST_U2    = 4'h2,
    ULP_ST_U3    = 4'h6,
    ULP_ST_RECOV = 4'h7,
    ULP_ST_INACT = 4'h5,
    ULP_ST_DISAB = 4'h4,
    ULP_ST_COMPL = 4'hc
  } ulp_state_e;
endpackage

//--- design/ulp_tmr_if.sv
/*
  Carrier between the state machine and one interval timer.
  Assumes both ends share clk.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ulp_params.svh"
interface ulp_tmr_if;
  logic                 restart;
  logic                 run;
  logic [`ULP_TW-1:0]   limit;
  logic                 expired;
  modport ctl (output restart, output run, output limit, input expired);
  modport tmr (input restart, input run, input limit, output expired);
endinterface
`default_nettype wire

//--- design/ulp_timer.sv
/*
  Interval timer: counts while run, cleared by restart, pulses expired for one
  cycle after limit running cycles and then starts over. Limit zero never fires.
  Assumes restart and run come from logic on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ulp_params.svh"
module ulp_timer (
  input  wire logic clk,  // block clock
  input  wire logic rst,  // async reset, high
  ulp_tmr_if.tmr    t     // control and expiry
);
  logic [`ULP_TW-1:0] count;
  logic [`ULP_TW-1:0] next_count;
  logic               next_expired;
  logic               hit;

  always_comb begin
    hit          = (t.limit != '0) && (count == t.limit - `ULP_TW'(1));
    next_count   = count;
    next_expired = 1'b0;
    if (t.restart) begin
      next_count = '0;
    end else if (t.run) begin
      next_expired = hit;
      next_count   = hit ? '0 : count + `ULP_TW'(1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count     <= '0;
      t.expired <= 1'b0;
    end else begin
      count     <= next_count;
      t.expired <= next_expired;
    end
  end
endmodule
`default_nettype wire

//--- design/ulp_top.sv
/*
  Link power-state machine for Compliance Mode and U0..U3 with its timers,
  keep-alive, liveness checks and exits to recovery, inactive, disabled and
  rx detect. Assumes all event inputs are one-cycle pulses from logic on clk,
  except vbus_valid, which is a pin and is synchronised here.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ulp_params.svh"
module ulp_top #(
  parameter logic [`ULP_TW-1:0] LCMD_CYC  = `ULP_TW'(`ULP_LCMD_CYC),
  parameter logic [`ULP_TW-1:0] PING_CYC  = `ULP_TW'(`ULP_PING_CYC),
  parameter logic [`ULP_TW-1:0] HS_UX_CYC = `ULP_TW'(`ULP_HS_UX_CYC),
  parameter logic [`ULP_TW-1:0] HS_U3_CYC = `ULP_TW'(`ULP_HS_U3_CYC),
  parameter logic [`ULP_TW-1:0] TERM_CYC  = `ULP_TW'(`ULP_TERM_CYC),
  parameter logic [`ULP_TW-1:0] RETRY_CYC = `ULP_TW'(`ULP_RETRY_CYC)
) (
  input  wire logic              clk,            // 10 MHz
  input  wire logic              rst,            // async reset, high
  input  wire logic              downstream,     // 1 = downstream port
  input  wire logic              self_powered,   // upstream self-powered
  input  wire logic              vbus_valid,     // pin, asynchronous
  input  wire logic              enter_u0,       // outer fsm hands over to U0
  input  wire logic              enter_compl,    // outer fsm hands over to compliance
  input  wire logic              ping_det,       // Ping.LFPS received
  input  wire logic              warm_reset_det, // upstream: warm reset seen
  input  wire logic              dir_warm_reset, // downstream: issue warm reset
  input  wire logic              dir_disable,    // directed to disabled
  input  wire logic              dir_inactive,   // directed to inactive
  input  wire logic              dir_recovery,   // directed to recovery
  input  wire logic              lcmd_rx,        // link command received
  input  wire logic              tx_busy,        // link command or packet on air
  input  wire logic              ts1_det,        // TS1 detected
  input  wire logic              link_err,       // error needing retrain
  input  wire logic              hp_timeout,     // pending header timer expired
  input  wire logic              hp_ok,          // pending header acknowledged
  input  wire logic              lgo_u1_ok,      // U1 entry sequence done
  input  wire logic              lgo_u2_ok,      // U2 entry sequence done
  input  wire logic              lgo_u3_ok,      // U3 entry sequence done
  input  wire logic              u3_entry_fail,  // U3 entry attempt failed
  input  wire logic [`ULP_TW-1:0] u2_timeout,    // U2 inactivity, cycles, 0 = off
  input  wire logic              exit_req,       // local wish to leave Ux
  input  wire logic              exit_det,       // partner exit/wake signalling
  input  wire logic              hs_ok,          // exit handshake complete
  input  wire logic              far_hiz,        // termination check: high imp
  output logic [3:0]             link_state,     // current state code
  output logic                   go_recovery,    // pulse: entered recovery
  output logic                   go_inactive,    // pulse: entered inactive
  output logic                   go_disabled,    // pulse: entered disabled
  output logic                   go_rxdetect,    // pulse: entered rx detect
  output logic                   lup_send,       // pulse: send one keep-alive
  output logic                   term_chk,       // pulse: run termination check
  output logic                   lfps_tx_en,     // LFPS transmitter on
  output logic                   exit_det_en,    // exit/wake detector armed
  output logic                   ping_det_en,    // ping detector armed
  output logic                   wake_blocked,   // U3 retry hold-off running
  output logic [3:0]             compl_pattern   // compliance pattern index
);
  localparam int T_LC = 0, T_IDLE = 1, T_PING = 2, T_HS = 3, T_TERM = 4;
  localparam int T_RETRY = 5, T_U2 = 6;

  ulp_pkg::ulp_state_e state, next_state;
  logic [1:0] hp_cnt, next_hp_cnt;
  logic [1:0] u3f_cnt, next_u3f_cnt;
  logic [3:0] pat, next_pat;
  logic       hs_act, next_hs_act;
  logic       hs_init, next_hs_init;
  logic       blk, next_blk;
  logic       vbus_s1, vbus_s2;
  logic       warm, vbus_off, in_ux;

  ulp_tmr_if tif [`ULP_NTMR] ();

  genvar gi;
  generate
    for (gi = 0; gi < `ULP_NTMR; gi++) begin : g_tmr
      ulp_timer u_tmr (.clk(clk), .rst(rst), .t(tif[gi]));
    end
  endgenerate

  function automatic logic is_ux(input ulp_pkg::ulp_state_e s);
    return (s == ulp_pkg::ULP_ST_U1) || (s == ulp_pkg::ULP_ST_U2) ||
           (s == ulp_pkg::ULP_ST_U3);
  endfunction

  // vbus is a board level; first flop feeds only the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      vbus_s1 <= 1'b0;
      vbus_s2 <= 1'b0;
    end else begin
      vbus_s1 <= vbus_valid;
      vbus_s2 <= vbus_s1;
    end
  end

  assign warm     = downstream ? dir_warm_reset : warm_reset_det;
  assign vbus_off = !downstream && self_powered && !vbus_s2;
  assign in_ux    = is_ux(state);

  assign tif[T_LC].restart    = (state != ulp_pkg::ULP_ST_U0) || lcmd_rx;
  assign tif[T_LC].run        = downstream;
  assign tif[T_LC].limit      = LCMD_CYC;
  // idle timer held at zero while anything is sent, counts in logical idle on an upstream port only
  assign tif[T_IDLE].restart  = (state != ulp_pkg::ULP_ST_U0) || tx_busy;
  assign tif[T_IDLE].run      = !downstream;
  assign tif[T_IDLE].limit    = `ULP_TW'(`ULP_IDLE_CYC);
  assign tif[T_PING].restart  = (state != ulp_pkg::ULP_ST_U1) || ping_det;
  assign tif[T_PING].run      = downstream;
  assign tif[T_PING].limit    = PING_CYC;
  assign tif[T_HS].restart    = !hs_act;
  assign tif[T_HS].run        = 1'b1;
  assign tif[T_HS].limit      = (state == ulp_pkg::ULP_ST_U3) ? HS_U3_CYC : HS_UX_CYC;
  assign tif[T_TERM].restart  = !((state == ulp_pkg::ULP_ST_U2) ||
                                  (state == ulp_pkg::ULP_ST_U3));
  assign tif[T_TERM].run      = downstream;
  assign tif[T_TERM].limit    = TERM_CYC;
  assign tif[T_RETRY].restart = !blk;
  assign tif[T_RETRY].run     = 1'b1;
  assign tif[T_RETRY].limit   = RETRY_CYC;
  // no drift into U2 while an exit handshake is under way
  assign tif[T_U2].restart    = (state != ulp_pkg::ULP_ST_U1) || hs_act;
  assign tif[T_U2].run        = 1'b1;
  assign tif[T_U2].limit      = u2_timeout;

  always_comb begin
    next_state   = state;
    next_pat     = pat;
    next_hp_cnt  = hp_cnt;
    next_u3f_cnt = u3f_cnt;
    next_hs_act  = hs_act;
    next_hs_init = hs_init;
    next_blk     = blk;
    if (hp_ok) begin
      next_hp_cnt = 2'h0;
    end
    if (lgo_u3_ok) begin
      next_u3f_cnt = 2'h0;
    end
    case (state)
      ulp_pkg::ULP_ST_COMPL: begin
        if (warm) begin
          next_state = ulp_pkg::ULP_ST_RXDET;
        end else if (downstream && dir_disable) begin
          next_state = ulp_pkg::ULP_ST_DISAB;
        end else if (ping_det) begin
          next_pat = (pat == `ULP_CPAT_LAST) ? `ULP_CPAT_FIRST :
                     pat + 4'h1;
        end
      end
      ulp_pkg::ULP_ST_U0: begin
        if (warm) begin
          next_state = ulp_pkg::ULP_ST_RXDET;
        end else if (dir_disable || vbus_off) begin
          next_state = ulp_pkg::ULP_ST_DISAB;
        end else if (downstream && dir_inactive) begin
          next_state = ulp_pkg::ULP_ST_INACT;
        end else if (hp_timeout) begin
          next_hp_cnt = (hp_cnt == `ULP_HP_LAST) ? 2'h0 : hp_cnt + 2'h1;
          next_state  = (hp_cnt == `ULP_HP_LAST) ? ulp_pkg::ULP_ST_INACT :
                        ulp_pkg::ULP_ST_RECOV;
        end else if (downstream && u3_entry_fail) begin
          next_u3f_cnt = (u3f_cnt == `ULP_U3F_LAST) ? 2'h0 : u3f_cnt + 2'h1;
          if (u3f_cnt == `ULP_U3F_LAST) begin
            next_state = ulp_pkg::ULP_ST_INACT;
          end
        end else if (ts1_det || link_err || dir_recovery || tif[T_LC].expired) begin
          next_state = ulp_pkg::ULP_ST_RECOV;
        end else if (lgo_u1_ok) begin
          next_state = ulp_pkg::ULP_ST_U1;
        end else if (lgo_u2_ok) begin
          next_state = ulp_pkg::ULP_ST_U2;
        end else if (lgo_u3_ok) begin
          next_state = ulp_pkg::ULP_ST_U3;
        end
      end
      ulp_pkg::ULP_ST_U1, ulp_pkg::ULP_ST_U2, ulp_pkg::ULP_ST_U3: begin
        if (blk && tif[T_RETRY].expired) begin
          next_blk = 1'b0;
        end
        if (warm) begin
          next_state = ulp_pkg::ULP_ST_RXDET;
        end else if ((downstream && dir_disable) || vbus_off) begin
          next_state = ulp_pkg::ULP_ST_DISAB;
        end else if (downstream && (state == ulp_pkg::ULP_ST_U1) &&
                     tif[T_PING].expired) begin
          next_state = ulp_pkg::ULP_ST_RXDET;
        end else if (downstream && (state != ulp_pkg::ULP_ST_U1) && far_hiz) begin
          next_state = ulp_pkg::ULP_ST_RXDET;
        end else if (hs_act) begin
          if (hs_ok) begin
            next_state = ulp_pkg::ULP_ST_RECOV;
          end else if (tif[T_HS].expired) begin
            if (state == ulp_pkg::ULP_ST_U3) begin
              next_hs_act = 1'b0;
              next_blk    = 1'b1;
            end else begin
              next_state = ulp_pkg::ULP_ST_INACT;
            end
          end
        // ping_det is never an exit cause, so U2 pings are ignored here
        end else if (exit_det) begin
          next_hs_act  = 1'b1;
          next_hs_init = 1'b0;
        end else if (exit_req && !blk) begin
          next_hs_act  = 1'b1;
          next_hs_init = 1'b1;
        end else if ((state == ulp_pkg::ULP_ST_U1) && tif[T_U2].expired) begin
          next_state = ulp_pkg::ULP_ST_U2;
        end
      end
      default: begin
        if (enter_compl) begin
          next_state = ulp_pkg::ULP_ST_COMPL;
          next_pat   = `ULP_CPAT_FIRST;
        end else if (enter_u0) begin
          next_state = ulp_pkg::ULP_ST_U0;
        end
      end
    endcase
    // a handshake or hold-off belongs to the state it started in
    if (next_state != state) begin
      next_hs_act  = 1'b0;
      next_hs_init = 1'b0;
      next_blk     = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state       <= ulp_pkg::ULP_ST_RXDET;
      pat         <= `ULP_CPAT_FIRST;
      hp_cnt      <= 2'h0;
      u3f_cnt     <= 2'h0;
      hs_act      <= 1'b0;
      hs_init     <= 1'b0;
      blk         <= 1'b0;
      go_recovery <= 1'b0;
      go_inactive <= 1'b0;
      go_disabled <= 1'b0;
      go_rxdetect <= 1'b0;
    end else begin
      state       <= next_state;
      pat         <= next_pat;
      hp_cnt      <= next_hp_cnt;
      u3f_cnt     <= next_u3f_cnt;
      hs_act      <= next_hs_act;
      hs_init     <= next_hs_init;
      blk         <= next_blk;
      go_recovery <= (next_state != state) && (next_state == ulp_pkg::ULP_ST_RECOV);
      go_inactive <= (next_state != state) && (next_state == ulp_pkg::ULP_ST_INACT);
      go_disabled <= (next_state != state) && (next_state == ulp_pkg::ULP_ST_DISAB);
      go_rxdetect <= (next_state != state) && (next_state == ulp_pkg::ULP_ST_RXDET);
    end
  end

  assign link_state    = state;
  assign compl_pattern = pat;
  assign lup_send      = tif[T_IDLE].expired;
  assign term_chk      = tif[T_TERM].expired;
  assign lfps_tx_en    = in_ux && hs_act && hs_init;
  assign exit_det_en   = in_ux;
  assign ping_det_en   = downstream && ((state == ulp_pkg::ULP_ST_U1) ||
                                        (state == ulp_pkg::ULP_ST_U2));
  assign wake_blocked  = blk;

  compl_step_a: assert property (@(posedge clk) disable iff (rst)
    state == ulp_pkg::ULP_ST_COMPL && ping_det && !warm && !dir_disable &&
    pat != `ULP_CPAT_LAST |=> pat == $past(pat) + 4'h1)
    else $error("compliance pattern did not step");
  compl_wrap_a: assert property (@(posedge clk) disable iff (rst)
    state == ulp_pkg::ULP_ST_COMPL && ping_det && !warm && !dir_disable &&
    pat == `ULP_CPAT_LAST |=> pat == `ULP_CPAT_FIRST)
    else $error("compliance pattern did not wrap");
  lup_single_a: assert property (@(posedge clk) disable iff (rst)
    lup_send |=> !lup_send ##1 !lup_send)
    else $error("keep-alive sent more than once");
  lgo_entry_a: assert property (@(posedge clk) disable iff (rst)
    state == ulp_pkg::ULP_ST_U0 ##1 state == ulp_pkg::ULP_ST_U1 |-> $past(lgo_u1_ok))
    else $error("U1 entered without entry sequence");
  hp_fourth_a: assert property (@(posedge clk) disable iff (rst)
    state == ulp_pkg::ULP_ST_U0 && hp_timeout && hp_cnt == `ULP_HP_LAST &&
    !warm && !dir_disable && !vbus_off |=> state == ulp_pkg::ULP_ST_INACT && go_inactive)
    else $error("fourth header timeout did not go inactive");
  u3_fail_a: assert property (@(posedge clk) disable iff (rst)
    state == ulp_pkg::ULP_ST_U0 && downstream && u3_entry_fail && !hp_timeout &&
    u3f_cnt == `ULP_U3F_LAST && !warm && !dir_disable && !dir_inactive
    |=> state == ulp_pkg::ULP_ST_INACT)
    else $error("third U3 entry failure did not go inactive");
  lfps_init_a: assert property (@(posedge clk) disable iff (rst)
    $rose(lfps_tx_en) |-> $past(exit_req) && !$past(blk) && exit_det_en)
    else $error("LFPS transmit without initiating exit");
  u3_detect_a: assert property (@(posedge clk) disable iff (rst)
    state == ulp_pkg::ULP_ST_U3 |-> !ping_det_en && exit_det_en)
    else $error("U3 detector arming wrong");
  u3_retry_a: assert property (@(posedge clk) disable iff (rst)
    state == ulp_pkg::ULP_ST_U3 && hs_act && tif[T_HS].expired && !hs_ok && !warm &&
    !far_hiz && !dir_disable && !vbus_off |=> (state == ulp_pkg::ULP_ST_U3 && blk) [*3])
    else $error("U3 wake timeout handling wrong");
endmodule
`default_nettype wire

//--- bench/ulp_partner.sv
/* Link partner model: periodic pings while it sits in U1, and the exit handshake answer.
   Assumes the bench sets ping_on and answer at the falling edge. */
`timescale 1ns/1ns
`default_nettype none
module ulp_partner (
  input  wire logic clk,        // block clock
  input  wire logic ping_on,    // partner sits in U1
  input  wire logic answer,     // partner completes handshakes
  input  wire logic lfps_tx_en, // local side signals an exit
  output logic      ping_det,   // one-cycle ping
  output logic      hs_ok       // one-cycle handshake done
);
  int pc = 0;
  int hc = 0;
  // ping period kept well inside the liveness timer
  always @(negedge clk) begin
    pc = ping_on ? (pc + 1) % 30 : 0;
    ping_det <= ping_on && pc == 29;
    hc = (lfps_tx_en && answer) ? hc + 1 : 0;
    hs_ok <= hc == 6;
  end
endmodule
`default_nettype wire

//--- bench/tb_ulp_top.sv
/* Directed bench for ulp_top, one task per scenario, shortened timers.
   Assumes the partner model answers exits and pings in U1. */
`timescale 1ns/1ns
`default_nettype none
`include "ulp_params.svh"
module tb_ulp_top;
  logic        clk = 0;
  logic        rst = 1;
  logic        downstream = 1;
  logic        tx_busy = 0;
  logic        ping_on = 0;
  logic        answer = 1;
  logic        self_powered = 0;
  logic        vbus_valid = 1;
  logic [21:0] u2_timeout = '0;
  logic [20:0] ev = '0;
  logic        ping_det, hs_ok, lup_send, term_chk, lfps_tx_en;
  logic        exit_det_en, ping_det_en, wake_blocked;
  logic [3:0]  link_state, compl_pattern;
  logic        go_recovery, go_inactive, go_disabled, go_rxdetect;
  logic [3:0]  go_v;
  // shortened timers so every exit fits in one short run
  localparam logic [21:0] LC_CYC = 22'h32, PG_CYC = 22'hc8, HX_CYC = 22'h28;
  localparam logic [21:0] H3_CYC = 22'h3c, TM_CYC = 22'h1e, RT_CYC = 22'h50;
  int          err_total = 0;
  int          n_checks = 0;
  int          cyc = 0;
  always #50 clk = ~clk;
  ulp_partner ulp_partner_i (.clk, .ping_on, .answer, .lfps_tx_en, .ping_det, .hs_ok);
  ulp_top #(.LCMD_CYC(LC_CYC), .PING_CYC(PG_CYC), .HS_UX_CYC(HX_CYC), .HS_U3_CYC(H3_CYC),
    .TERM_CYC(TM_CYC), .RETRY_CYC(RT_CYC)) ulp_top_i (
    .clk, .rst, .downstream, .self_powered, .vbus_valid, .enter_u0(ev[0]),
    .enter_compl(ev[1]), .ping_det(ev[2] | ping_det), .warm_reset_det(ev[3]),
    .dir_warm_reset(ev[4]), .dir_disable(ev[5]), .dir_inactive(ev[6]), .dir_recovery(ev[7]),
    .lcmd_rx(ev[8]), .tx_busy, .ts1_det(ev[9]), .link_err(ev[10]), .hp_timeout(ev[11]),
    .hp_ok(ev[12]), .lgo_u1_ok(ev[13]), .lgo_u2_ok(ev[14]), .lgo_u3_ok(ev[15]),
    .u3_entry_fail(ev[16]), .u2_timeout, .exit_req(ev[17]), .exit_det(ev[18]),
    .hs_ok, .far_hiz(ev[20]), .link_state, .go_recovery, .go_inactive, .go_disabled,
    .go_rxdetect, .lup_send, .term_chk, .lfps_tx_en, .exit_det_en, .ping_det_en,
    .wake_blocked, .compl_pattern);
  assign go_v = {go_recovery, go_inactive, go_disabled, go_rxdetect};
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      err_total++;
      report_and_stop;
    end
  end
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one-cycle pulse, sampled by exactly one rising edge
  task automatic pulse(input int i);
    @(negedge clk) ev[i] = 1'b1;
    @(negedge clk) ev[i] = 1'b0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wait_st(input logic [3:0] exp, input int lim);
    for (int k = 0; k < lim && link_state !== exp; k++) @(negedge clk);
    chk(link_state, exp);
  endtask
  task automatic cnt_pulses(input int c, output int nl, output int nt);
    nl = 0;
    nt = 0;
    repeat (c) begin
      @(negedge clk);
      nl += (lup_send === 1'b1);
      nt += (term_chk === 1'b1);
    end
  endtask
  task automatic t_compl;
    pulse(1);
    for (int i = 1; i <= 9; i++) begin
      pulse(2);
      chk(compl_pattern, 4'(i % 9));
    end
    pulse(7);
    chk(link_state, ulp_pkg::ULP_ST_COMPL);
    pulse(4);
    chk(link_state, ulp_pkg::ULP_ST_RXDET);
    chk(go_v, 4'h1);
    pulse(1);
    pulse(5);
    chk({go_v[1], link_state[2:0]}, 4'hc);
    $display("test compliance done");
  endtask
  task automatic t_u0;
    pulse(0);
    repeat (3) begin
      idle(40);
      pulse(8);
    end
    idle(45);
    chk(link_state, ulp_pkg::ULP_ST_U0);
    wait_st(ulp_pkg::ULP_ST_RECOV, 15);
    pulse(0);
    pulse(11);
    pulse(0);
    pulse(12);
    pulse(9);
    chk(link_state, ulp_pkg::ULP_ST_RECOV);
    chk(go_v, 4'h8);
    pulse(0);
    pulse(10);
    chk({go_v[3], link_state[2:0]}, 4'hf);
    pulse(0);
    pulse(7);
    chk({go_v[3], link_state[2:0]}, 4'hf);
    for (int i = 0; i < 4; i++) begin
      pulse(0);
      pulse(11);
      chk(link_state, i < 3 ? ulp_pkg::ULP_ST_RECOV : ulp_pkg::ULP_ST_INACT);
    end
    pulse(0);
    pulse(6);
    chk({go_v[2], link_state[2:0]}, 4'hd);
    $display("test u0 done");
  endtask
  task automatic t_ux;
    ping_on = 1'b1;
    pulse(0);
    pulse(13);
    chk({1'b0, ping_det_en, exit_det_en, lfps_tx_en}, 4'h6);
    idle(300);
    chk(link_state, ulp_pkg::ULP_ST_U1);
    pulse(17);
    chk({3'h0, lfps_tx_en}, 4'h1);
    wait_st(ulp_pkg::ULP_ST_RECOV, 20);
    ping_on = 1'b0;
    pulse(0);
    pulse(13);
    idle(190);
    chk(link_state, ulp_pkg::ULP_ST_U1);
    wait_st(ulp_pkg::ULP_ST_RXDET, 20);
    answer = 1'b0;
    u2_timeout = 22'h14;
    pulse(0);
    pulse(13);
    idle(15);
    chk(link_state, ulp_pkg::ULP_ST_U1);
    wait_st(ulp_pkg::ULP_ST_U2, 10);
    u2_timeout = 22'h0;
    // a ping taken as an exit would time out to inactive inside this wait
    pulse(2);
    idle(45);
    chk(link_state, ulp_pkg::ULP_ST_U2);
    pulse(18);
    idle(30);
    chk({link_state[2:0], lfps_tx_en}, 4'h4);
    wait_st(ulp_pkg::ULP_ST_INACT, 20);
    pulse(0);
    pulse(14);
    chk(link_state, ulp_pkg::ULP_ST_U2);
    pulse(4);
    chk({go_v[0], link_state[2:0]}, 4'h8);
    $display("test u1 u2 done");
  endtask
  task automatic t_u3;
    int nl, nt;
    pulse(0);
    pulse(16);
    pulse(16);
    pulse(15);
    chk({1'b0, ping_det_en, exit_det_en, link_state[2]}, 4'h3);
    pulse(17);
    cnt_pulses(70, nl, nt);
    chk(4'(nt), 4'h2);
    chk({wake_blocked, link_state[2:0]}, 4'he);
    pulse(17);
    chk({3'h0, lfps_tx_en}, 4'h0);
    idle(80);
    pulse(17);
    chk({wake_blocked, 2'h0, lfps_tx_en}, 4'h1);
    pulse(20);
    chk(link_state, ulp_pkg::ULP_ST_RXDET);
    pulse(0);
    for (int i = 1; i <= 3; i++) begin
      pulse(16);
      chk(link_state, i < 3 ? ulp_pkg::ULP_ST_U0 : ulp_pkg::ULP_ST_INACT);
    end
    $display("test u3 done");
  endtask
  task automatic t_up;
    int n, m;
    downstream = 1'b0;
    tx_busy = 1'b1;
    pulse(0);
    cnt_pulses(150, n, m);
    chk(4'(n), 4'h0);
    tx_busy = 1'b0;
    cnt_pulses(250, n, m);
    chk(4'(n), 4'h2);
    chk(4'(m), 4'h0);
    pulse(5);
    chk({go_v[1], link_state[2:0]}, 4'hc);
    pulse(0);
    self_powered = 1'b1;
    vbus_valid = 1'b0;
    idle(3);
    chk({go_v[1], link_state[2:0]}, 4'hc);
    vbus_valid = 1'b1;
    idle(3);
    pulse(0);
    pulse(13);
    chk(link_state, ulp_pkg::ULP_ST_U1);
    vbus_valid = 1'b0;
    idle(3);
    chk({go_v[1], link_state[2:0]}, 4'hc);
    pulse(1);
    pulse(5);
    chk(link_state, ulp_pkg::ULP_ST_COMPL);
    pulse(3);
    chk({go_v[0], link_state[2:0]}, 4'h8);
    $display("test upstream done");
  endtask
  initial begin
    idle(10);
    rst = 1'b0;
    t_compl;
    t_u0;
    t_ux;
    t_u3;
    t_up;
    report_and_stop;
  end
endmodule
`default_nettype wire
